// ---- rtl/pmcm_top.sv ----
`timescale 1ns/100ps

// Functional notes
// - Active clocks the processor and enabled peripherals from the selected source.
// - Idle gates processor and memory clocks, peripherals keep running.
// - Any interrupt returns Idle to Active.
// - Standby keeps always-on and co-processor domains; pin, timer or co-processor wake.
// - Standby wake keeps retained configuration; processor resumes where it stopped.
// - All I/O pins are latched while in Standby.
// - Shutdown powers everything off and holds pins at pre-entry values.
// - Shutdown wake-pin level change wakes device as a reset.
// - Reset cause register separates wake-pin, reset-pin and power-on resets.
// - Only latched pins and program memory survive Shutdown.
// - Retention is full in Active/Idle, partial in Standby, none otherwise.
// - Main clock from crystal or RC in Active/Idle, stopped elsewhere.
// - Medium clock runs Active/Idle, available Standby, off otherwise.
// - Low clock runs Active/Idle/Standby, off in Shutdown or reset.
// - Reset pin wakes the device from every mode.
// - Radio allowed only with main clock from the crystal.
// - Medium clock always sourced from its RC oscillator.
// - Low clock source choices are RC, crystal or pin input.
// - Low clock may be routed out when sourced from crystal or RC.
// - Watchdog pauses in Standby and resumes on return.

module pmcm_top (
	// Clock and power-on reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// External pins
	input wire logic reset_pin_n_in,
	input wire logic [7:0] gpio_in,
	input wire logic [7:0] gpio_wake_en_in,
	// Wake events
	input wire logic irq_in,
	input wire logic pin_wake_in,
	input wire logic rtc_event_in,
	input wire logic coproc_event_in,
	// Software control
	input wire logic sleep_req_in,
	input wire logic [1:0] sleep_mode_in,
	input wire logic hf_xtal_sel_in,
	input wire logic [1:0] lf_src_sel_in,
	input wire logic lf_out_en_in,
	input wire logic radio_req_in,
	input wire logic wdt_en_in,
	input wire logic cause_clr_in,
	// Clock gates and enables
	output logic cpu_clk_en_out,
	output logic mem_clk_en_out,
	output logic periph_clk_en_out,
	output logic main_system_clock_en_out,
	output logic hf_crystal_oscillator_en_out,
	output logic hf_rc_oscillator_en_out,
	output logic medium_speed_clock_en_out,
	output logic mf_rc_oscillator_en_out,
	output logic low_frequency_clock_en_out,
	output logic [1:0] lf_src_out,
	output logic lf_clk_out_en_out,
	output logic radio_en_out,
	// Power domains
	output logic always_on_domain_on_out,
	output logic coproc_on_out,
	output logic periph_pwr_on_out,
	output logic [1:0] retention_out,
	output logic cpu_resume_out,
	output logic sys_reset_out,
	// Pins and status
	output logic gpio_latch_out,
	output logic [7:0] gpio_hold_out,
	output logic [2:0] mode_out,
	output logic [2:0] reset_cause_out,
	output logic [15:0] watchdog_counter_out
);

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************

	logic [12:0] sync_raw;
	logic [12:0] sync_val;
	logic rst_pin_s;
	logic irq_s;
	logic pin_wake_s;
	logic rtc_s;
	logic cop_s;
	logic [7:0] gpio_s;

	assign sync_raw = {~reset_pin_n_in, irq_in, pin_wake_in, rtc_in_w(rtc_event_in), coproc_event_in,
		gpio_in[0], gpio_in[1], gpio_in[2], gpio_in[3], gpio_in[4], gpio_in[5], gpio_in[6], gpio_in[7]};

	function automatic logic rtc_in_w(input logic v);
		rtc_in_w = v;
	endfunction : rtc_in_w

	pmcm_sync #(
		.WIDTH(13)
	) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(sync_raw),
		.sync_out(sync_val)
	);

	assign rst_pin_s = sync_val[12];
	assign irq_s = sync_val[11];
	assign pin_wake_s = sync_val[10];
	assign rtc_s = sync_val[9];
	assign cop_s = sync_val[8];
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_gpio
			assign gpio_s[gi] = sync_val[7 - gi];
		end
	endgenerate

	// ****************************************************************
	// Mode state machine
	// ****************************************************************

	pmcm_pkg::pmcm_mode_e mode_ff;
	pmcm_pkg::pmcm_mode_e nxt_mode;
	logic [1:0] target_ff;
	logic [7:0] hold_ff;
	logic [7:0] nxt_hold;
	logic [7:0] wake_ref_ff;
	logic [2:0] cause_ff;
	logic [2:0] nxt_cause;
	logic resume_ff;
	logic started_ff;
	logic in_active;
	logic in_idle;
	logic in_stby;
	logic in_shut;
	logic in_rst;
	logic run_mode;
	logic shut_wake;
	logic stby_wake;

	function automatic logic is_mode(input pmcm_pkg::pmcm_mode_e m, input pmcm_pkg::pmcm_mode_e q);
		is_mode = (m == q);
	endfunction : is_mode

	assign in_active = is_mode(mode_ff, pmcm_pkg::PMCM_ACTIVE);
	assign in_idle = is_mode(mode_ff, pmcm_pkg::PMCM_IDLE);
	assign in_stby = is_mode(mode_ff, pmcm_pkg::PMCM_STANDBY);
	assign in_shut = is_mode(mode_ff, pmcm_pkg::PMCM_SHUTDOWN);
	assign in_rst = is_mode(mode_ff, pmcm_pkg::PMCM_RESET_HELD);
	assign run_mode = in_active | in_idle;
	// A wake pin that leaves its latched level restarts the device.
	assign shut_wake = |((gpio_s ^ wake_ref_ff) & gpio_wake_en_in);
	assign stby_wake = pin_wake_s | rtc_s | cop_s;

	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			pmcm_pkg::PMCM_ACTIVE: begin
				if (sleep_req_in) begin
					unique case (target_ff)
						pmcm_pkg::PMCM_REQ_IDLE: nxt_mode = pmcm_pkg::PMCM_IDLE;
						pmcm_pkg::PMCM_REQ_STANDBY: nxt_mode = pmcm_pkg::PMCM_STANDBY;
						pmcm_pkg::PMCM_REQ_SHUTDOWN: nxt_mode = pmcm_pkg::PMCM_SHUTDOWN;
						pmcm_pkg::PMCM_REQ_NONE: nxt_mode = pmcm_pkg::PMCM_ACTIVE;
					endcase
				end
			end
			pmcm_pkg::PMCM_IDLE: begin
				if (irq_s) begin
					nxt_mode = pmcm_pkg::PMCM_ACTIVE;
				end
			end
			pmcm_pkg::PMCM_STANDBY: begin
				if (stby_wake) begin
					nxt_mode = pmcm_pkg::PMCM_ACTIVE;
				end
			end
			pmcm_pkg::PMCM_SHUTDOWN: begin
				if (shut_wake) begin
					nxt_mode = pmcm_pkg::PMCM_RESET_HELD;
				end
			end
			pmcm_pkg::PMCM_RESET_HELD: begin
				if (!rst_pin_s) begin
					nxt_mode = pmcm_pkg::PMCM_ACTIVE;
				end
			end
			default: nxt_mode = pmcm_pkg::PMCM_RESET_HELD;
		endcase
		if (rst_pin_s) begin
			nxt_mode = pmcm_pkg::PMCM_RESET_HELD;
		end
	end

	// The pins are frozen on the cycle a running mode passes to Standby or Shutdown.
	assign nxt_hold = (run_mode && (nxt_mode == pmcm_pkg::PMCM_STANDBY ||
		nxt_mode == pmcm_pkg::PMCM_SHUTDOWN)) ? gpio_s : hold_ff;

	always_comb begin
		nxt_cause = cause_ff;
		if (cause_clr_in) begin
			nxt_cause = '0;
		end
		// A new cause wins over a software clear in the same cycle.
		if (in_shut && shut_wake && !rst_pin_s) begin
			nxt_cause = 3'h4;
		end
		if (rst_pin_s && !in_rst) begin
			nxt_cause = 3'h2;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_ff <= pmcm_pkg::PMCM_RESET_HELD;
			started_ff <= 1'b0;
		end else begin
			mode_ff <= started_ff ? nxt_mode : pmcm_pkg::PMCM_ACTIVE;
			started_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_ff <= pmcm_pkg::PMCM_REQ_NONE;
		end else if (in_shut || in_rst) begin
			target_ff <= pmcm_pkg::PMCM_REQ_NONE;
		end else if (in_active && !sleep_req_in) begin
			target_ff <= sleep_mode_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hold_ff <= pmcm_pkg::PMCM_GPIO_RST;
			wake_ref_ff <= pmcm_pkg::PMCM_GPIO_RST;
			cause_ff <= pmcm_pkg::PMCM_CAUSE_RST;
		end else begin
			hold_ff <= nxt_hold;
			wake_ref_ff <= in_shut ? wake_ref_ff : gpio_s;
			cause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resume_ff <= 1'b0;
		end else begin
			resume_ff <= in_stby && nxt_mode == pmcm_pkg::PMCM_ACTIVE;
		end
	end

	// ****************************************************************
	// Watchdog counter
	// ****************************************************************

	logic [15:0] wdt_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wdt_ff <= pmcm_pkg::PMCM_WDT_RST;
		end else if (in_shut || in_rst) begin
			wdt_ff <= pmcm_pkg::PMCM_WDT_RST;
		end else if (run_mode && wdt_en_in) begin
			wdt_ff <= wdt_ff + 16'h0001;
		end
	end

	// ****************************************************************
	// Clock and power outputs
	// ****************************************************************

	logic lf_valid;

	assign lf_valid = lf_src_sel_in != 2'h3;
	assign cpu_clk_en_out = in_active;
	assign mem_clk_en_out = in_active;
	assign periph_clk_en_out = run_mode;
	assign main_system_clock_en_out = run_mode;
	assign hf_crystal_oscillator_en_out = run_mode & hf_xtal_sel_in;
	assign hf_rc_oscillator_en_out = run_mode & ~hf_xtal_sel_in;
	assign medium_speed_clock_en_out = run_mode | in_stby;
	assign mf_rc_oscillator_en_out = run_mode | in_stby;
	assign low_frequency_clock_en_out = run_mode | in_stby;
	assign lf_src_out = lf_valid ? lf_src_sel_in : pmcm_pkg::PMCM_LF_RC;
	assign lf_clk_out_en_out = low_frequency_clock_en_out & lf_out_en_in &
		(lf_src_out != pmcm_pkg::PMCM_LF_PIN);
	assign radio_en_out = run_mode & hf_xtal_sel_in & radio_req_in;
	assign always_on_domain_on_out = run_mode | in_stby;
	assign coproc_on_out = run_mode | in_stby;
	assign periph_pwr_on_out = run_mode;
	assign retention_out = run_mode ? pmcm_pkg::PMCM_RET_FULL :
		(in_stby ? pmcm_pkg::PMCM_RET_PARTIAL : pmcm_pkg::PMCM_RET_NONE);
	assign cpu_resume_out = resume_ff;
	assign sys_reset_out = in_rst | in_shut;
	assign gpio_latch_out = in_stby | in_shut;
	assign gpio_hold_out = hold_ff;
	assign mode_out = mode_ff;
	assign reset_cause_out = cause_ff;
	assign watchdog_counter_out = wdt_ff;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_idle_irq;
		in_idle && irq_s && !rst_pin_s;
	endsequence

	sequence s_stby_event;
		in_stby && stby_wake && !rst_pin_s;
	endsequence

	// The resume pulse is registered, so it stands in the first Active cycle.
	sequence s_resumed;
		in_active && cpu_resume_out;
	endsequence

	AST_IDLE_WAKE: assert property (s_idle_irq |=> in_active) else $error("Idle did not wake on irq");
	AST_STBY_WAKE: assert property (s_stby_event |=> s_resumed)
		else $error("Standby wake failed");
	AST_RESUME_ONCE: assert property (cpu_resume_out |=> !cpu_resume_out)
		else $error("Resume pulse too long");
	AST_IDLE_CPU: assert property (in_idle |-> !cpu_clk_en_out && periph_clk_en_out)
		else $error("Idle clock gating wrong");
	AST_LATCH: assert property (in_stby |-> gpio_latch_out ##1 $stable(gpio_hold_out))
		else $error("Pins not latched in standby");
	AST_SHUT_OFF: assert property (in_shut |-> !always_on_domain_on_out && !low_frequency_clock_en_out)
		else $error("Shutdown not fully off");
	AST_SHUT_HOLD: assert property (in_shut |=> $stable(gpio_hold_out))
		else $error("Pins moved in shutdown");
	AST_SHUT_WAKE: assert property (in_shut && shut_wake && !rst_pin_s |=> in_rst && reset_cause_out == 3'h4)
		else $error("Shutdown pin wake failed");
	AST_PIN_CAUSE: assert property (rst_pin_s && !in_rst |=> reset_cause_out == 3'h2)
		else $error("Reset pin cause not recorded");
	AST_RST_PIN: assert property (rst_pin_s && started_ff |=> in_rst) else $error("Reset pin ignored");
	AST_RADIO: assert property (radio_en_out |-> hf_crystal_oscillator_en_out) else $error("Radio without xtal");
	AST_WDT: assert property (in_stby |=> $stable(watchdog_counter_out)) else $error("Watchdog ran in standby");
	AST_RET: assert property (in_stby |-> retention_out == pmcm_pkg::PMCM_RET_PARTIAL)
		else $error("Standby retention wrong");
	AST_STBY_CLK: assert property (in_stby |-> medium_speed_clock_en_out && !main_system_clock_en_out)
		else $error("Standby clock set wrong");
	AST_LF_OUT: assert property (lf_clk_out_en_out |->
		low_frequency_clock_en_out && lf_src_out != pmcm_pkg::PMCM_LF_PIN)
		else $error("Low clock routed out from pin source");
	AST_STAY_ACTIVE: assert property (in_active && !sleep_req_in && !rst_pin_s |=> in_active)
		else $error("Left Active without request");

endmodule : pmcm_top

// ---- rtl/pmcm_pkg.sv ----
package pmcm_pkg;

	// ****************************************************************
	// Power modes and clock source selections
	// ****************************************************************

	typedef enum logic [2:0] {
		PMCM_ACTIVE = 3'h0,
		PMCM_IDLE = 3'h1,
		PMCM_STANDBY = 3'h2,
		PMCM_SHUTDOWN = 3'h3,
		PMCM_RESET_HELD = 3'h4
	} pmcm_mode_e;

	typedef enum logic [1:0] {
		PMCM_REQ_NONE = 2'h0,
		PMCM_REQ_IDLE = 2'h1,
		PMCM_REQ_STANDBY = 2'h2,
		PMCM_REQ_SHUTDOWN = 2'h3
	} pmcm_req_e;

	typedef enum logic [1:0] {
		PMCM_RET_NONE = 2'h0,
		PMCM_RET_PARTIAL = 2'h1,
		PMCM_RET_FULL = 2'h2
	} pmcm_ret_e;

	localparam logic [1:0] PMCM_LF_RC = 2'h0;
	localparam logic [1:0] PMCM_LF_XTAL = 2'h1;
	localparam logic [1:0] PMCM_LF_PIN = 2'h2;

	// ****************************************************************
	// Reset cause field positions and reset values
	// ****************************************************************

	localparam int PMCM_CAUSE_W = 3;
	localparam int PMCM_CAUSE_POR_BIT = 0;
	localparam int PMCM_CAUSE_PIN_BIT = 1;
	localparam int PMCM_CAUSE_WAKE_BIT = 2;
	localparam logic [2:0] PMCM_CAUSE_RST = 3'h1;
	localparam int PMCM_GPIO_W = 8;
	localparam logic [7:0] PMCM_GPIO_RST = 8'h00;

	// ****************************************************************
	// Watchdog timing
	// ****************************************************************

	localparam int PMCM_CLK_HZ = 10000000;
	localparam int PMCM_WDT_W = 16;
	localparam logic [15:0] PMCM_WDT_RST = 16'h0000;

endpackage : pmcm_pkg

// ---- rtl/pmcm_sync.sv ----
`timescale 1ns/100ps

// ****************************************************************
// Two flip-flop synchroniser for a bus of independent levels
// ****************************************************************

module pmcm_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : pmcm_sync

// ---- sim/pmcm_partner.sv ----
`timescale 1ns/100ps

// ****************************************************************
// Far side: reset pin, wake-capable pins and timer event
// ****************************************************************

module pmcm_partner (
	// Clock
	input wire logic clk_in,
	// Pins and events
	output logic reset_pin_n_out,
	output logic [7:0] gpio_out,
	output logic rtc_event_out
);
	initial begin
		reset_pin_n_out = 1'b1;
		gpio_out = 8'hA5;
		rtc_event_out = 1'b0;
	end

	// Levels change just after a rising edge, as a real pin would settle.
	task automatic drive_reset_pin(input logic v);
		@(posedge clk_in);
		#1 reset_pin_n_out = v;
	endtask : drive_reset_pin

	task automatic drive_gpio(input logic [7:0] v);
		@(posedge clk_in);
		#1 gpio_out = v;
	endtask : drive_gpio

	task automatic drive_timer_event(input logic v);
		@(posedge clk_in);
		#1 rtc_event_out = v;
	endtask : drive_timer_event
endmodule : pmcm_partner

// ---- sim/pmcm_top_tb.sv ----
`timescale 1ns/100ps

module pmcm_top_tb;
	logic clk_in = 1'b0, rst_n_in = 1'b0, irq_in = 1'b0, coproc_event_in = 1'b0;
	logic sleep_req_in = 1'b0, hf_xtal_sel_in = 1'b1, lf_out_en_in = 1'b1, radio_req_in = 1'b0;
	logic wdt_en_in = 1'b1, cause_clr_in = 1'b0, pin_wake_in = 1'b0;
	logic [1:0] sleep_mode_in = 2'h0, lf_src_sel_in = 2'h1;
	logic [7:0] gpio_wake_en_in = 8'h01;
	logic reset_pin_n, rtc_event;
	logic [7:0] gpio;
	logic cpu_clk, mem_clk, periph_clk, main_clk, hf_x, hf_rc, mf_clk, mf_rc, lf_clk, lf_out, radio_en;
	logic always_on_domain, coproc_on, periph_pwr, resume, sys_reset, gpio_latch;
	logic [1:0] lf_src, retention;
	logic [7:0] gpio_hold;
	logic [2:0] mode, cause;
	logic [15:0] wdt;
	int bad_count = 0;
	int samples_checked = 0;

	always #50 clk_in = ~clk_in;

	pmcm_partner u_pmcm_partner (.clk_in(clk_in), .reset_pin_n_out(reset_pin_n), .gpio_out(gpio),
		.rtc_event_out(rtc_event));

	pmcm_top u_pmcm_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .reset_pin_n_in(reset_pin_n), .gpio_in(gpio),
		.gpio_wake_en_in(gpio_wake_en_in), .irq_in(irq_in), .pin_wake_in(pin_wake_in), .rtc_event_in(rtc_event),
		.coproc_event_in(coproc_event_in), .sleep_req_in(sleep_req_in), .sleep_mode_in(sleep_mode_in),
		.hf_xtal_sel_in(hf_xtal_sel_in), .lf_src_sel_in(lf_src_sel_in), .lf_out_en_in(lf_out_en_in),
		.radio_req_in(radio_req_in), .wdt_en_in(wdt_en_in), .cause_clr_in(cause_clr_in),
		.cpu_clk_en_out(cpu_clk), .mem_clk_en_out(mem_clk), .periph_clk_en_out(periph_clk),
		.main_system_clock_en_out(main_clk), .hf_crystal_oscillator_en_out(hf_x), .hf_rc_oscillator_en_out(hf_rc),
		.medium_speed_clock_en_out(mf_clk), .mf_rc_oscillator_en_out(mf_rc), .low_frequency_clock_en_out(lf_clk),
		.lf_src_out(lf_src), .lf_clk_out_en_out(lf_out), .radio_en_out(radio_en), .always_on_domain_on_out(always_on_domain),
		.coproc_on_out(coproc_on), .periph_pwr_on_out(periph_pwr), .retention_out(retention),
		.cpu_resume_out(resume), .sys_reset_out(sys_reset), .gpio_latch_out(gpio_latch),
		.gpio_hold_out(gpio_hold), .mode_out(mode), .reset_cause_out(cause), .watchdog_counter_out(wdt));

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits a bounded number of edges for a mode; running out ends the run.
	task automatic wait_mode(input logic [2:0] m);
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_in);
			#1;
			if (mode === m) return;
		end
		bad_count++;
		$display("MISMATCH at %0t: mode %h never reached", $time, m);
		tally_and_finish();
	endtask : wait_mode

	// Target set, one quiet cycle, then a one-cycle request.
	task automatic enter_mode(input logic [1:0] m);
		@(posedge clk_in);
		#1 sleep_mode_in = m;
		@(posedge clk_in);
		#1 sleep_req_in = 1'b1;
		@(posedge clk_in);
		#1 sleep_req_in = 1'b0;
		sleep_mode_in = 2'h0;
	endtask : enter_mode

	task automatic scen_active_after_reset;
		check(cause, 16'h0001);
		check({cpu_clk, mem_clk, periph_clk, main_clk, hf_x, hf_rc}, 16'h003E);
		check({mf_clk, mf_rc, lf_clk, lf_src, lf_out}, 16'h003B);
		check(retention, 16'h0002);
		enter_mode(2'h0);
		check(mode, 16'h0000);
		cause_clr_in = 1'b1;
		@(posedge clk_in);
		#1 cause_clr_in = 1'b0;
		check(cause, 16'h0000);
	endtask : scen_active_after_reset

	task automatic scen_clock_sources;
		radio_req_in = 1'b1;
		hf_xtal_sel_in = 1'b0;
		@(posedge clk_in);
		#1 check({radio_en, hf_x, hf_rc}, 16'h0001);
		hf_xtal_sel_in = 1'b1;
		@(posedge clk_in);
		#1 check({radio_en, hf_x, hf_rc}, 16'h0006);
		radio_req_in = 1'b0;
		for (int s = 0; s < 4; s++) begin
			lf_src_sel_in = s[1:0];
			@(posedge clk_in);
			#1 check(lf_src, (s == 3) ? 16'h0000 : 16'(s));
			check(lf_out, {15'h0000, s != 2});
		end
		lf_src_sel_in = 2'h1;
		lf_out_en_in = 1'b0;
		@(posedge clk_in);
		#1 check(lf_out, 16'h0000);
		lf_out_en_in = 1'b1;
	endtask : scen_clock_sources

	task automatic scen_idle;
		enter_mode(2'h1);
		check(mode, 16'h0001);
		check({cpu_clk, mem_clk, periph_clk, main_clk, periph_pwr}, 16'h0007);
		check(retention, 16'h0002);
		irq_in = 1'b1;
		wait_mode(3'h0);
		irq_in = 1'b0;
		check(cpu_clk, 16'h0001);
	endtask : scen_idle

	task automatic scen_standby;
		logic [15:0] held;
		enter_mode(2'h2);
		check(mode, 16'h0002);
		check({gpio_latch, gpio_hold}, 16'h01A5);
		check({main_clk, periph_clk, mf_clk, lf_clk, always_on_domain, coproc_on}, 16'h000F);
		check(retention, 16'h0001);
		held = wdt;
		repeat (4) @(posedge clk_in);
		#1 check(wdt, held);
		u_pmcm_partner.drive_gpio(8'h3C);
		repeat (3) @(posedge clk_in);
		#1 check(gpio_hold, 16'h00A5);
		u_pmcm_partner.drive_timer_event(1'b1);
		wait_mode(3'h0);
		check(resume, 16'h0001);
		u_pmcm_partner.drive_timer_event(1'b0);
		check(resume, 16'h0000);
		check(retention, 16'h0002);
		repeat (2) @(posedge clk_in);
		#1 check(wdt > held, 16'h0001);
		wdt_en_in = 1'b0;
		held = wdt;
		repeat (3) @(posedge clk_in);
		#1 check(wdt, held);
		wdt_en_in = 1'b1;
		enter_mode(2'h2);
		coproc_event_in = 1'b1;
		wait_mode(3'h0);
		coproc_event_in = 1'b0;
		check(resume, 16'h0001);
		enter_mode(2'h2);
		pin_wake_in = 1'b1;
		wait_mode(3'h0);
		pin_wake_in = 1'b0;
		check(resume, 16'h0001);
		check(mode, 16'h0000);
	endtask : scen_standby

	task automatic scen_shutdown;
		gpio_wake_en_in = 8'h02;
		enter_mode(2'h3);
		check(mode, 16'h0003);
		check({gpio_latch, gpio_hold}, 16'h013C);
		check({always_on_domain, coproc_on, main_clk, mf_clk, lf_clk, retention}, 16'h0000);
		check(sys_reset, 16'h0001);
		u_pmcm_partner.drive_gpio(8'h3D);
		repeat (6) @(posedge clk_in);
		#1 check(mode, 16'h0003);
		check(wdt, 16'h0000);
		check(gpio_hold, 16'h003C);
		u_pmcm_partner.drive_gpio(8'h3F);
		wait_mode(3'h4);
		check(cause, 16'h0004);
		wait_mode(3'h0);
		gpio_wake_en_in = 8'h01;
	endtask : scen_shutdown

	task automatic scen_reset_pin;
		enter_mode(2'h2);
		u_pmcm_partner.drive_reset_pin(1'b0);
		wait_mode(3'h4);
		check({cause[1], sys_reset, retention, lf_clk, mf_clk}, 16'h0030);
		u_pmcm_partner.drive_reset_pin(1'b1);
		wait_mode(3'h0);
		check(cause, 16'h0002);
	endtask : scen_reset_pin

	initial begin
		repeat (5) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		wait_mode(3'h0);
		scen_active_after_reset();
		scen_clock_sources();
		scen_idle();
		scen_standby();
		scen_shutdown();
		scen_reset_pin();
		tally_and_finish();
	end
endmodule : pmcm_top_tb
